// File: rtl/cfc_top.sv
// Filter data bit count and interrupt enable registers with AHB-Lite slave
//
// What this block does
// - Count zero compares no payload bits; identifier alone decides.
// - Count one compares data byte 1 bit 7 with identifier bit 0.
// - Count seventeen compares up to byte 3 bit 6 with identifier bit 17.
// - Enable bit 7 gates the invalid message event.
// - Enable bit 6 gates the bus wake-up activity event.
// - Enable bit 5 gates the error event.
// - Enable bit 3 gates the receive FIFO almost-full event.
// - Enable bit 2 gates the receive buffer overflow event.
// - Enable bit 1 gates receive buffer, bit 0 gates transmit buffer event.
// - Enable bits are read/write, reset to zero; one passes, zero blocks.
// - Unused bits of both registers read as zero.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cfc_top (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic      [31:0]  hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // Controller events, one-cycle pulses
    input  wire logic [7:0]   event_pulse,
    // Acceptance comparison request
    input  wire logic         flt_req,
    input  wire logic [17:0]  flt_eid,
    input  wire logic [23:0]  flt_payload,
    // Acceptance comparison result
    output logic              flt_valid,
    output logic              flt_data_match,
    // Interrupt
    output logic              irq
);
    cfc_pkg::cfc_phase_e         phase_reg;
    cfc_pkg::cfc_phase_e         phase_next;
    logic [11:0]                 addr_reg;
    logic [cfc_pkg::FCNT_W-1:0]  fcnt_reg;
    logic [7:0]                  inte_reg;
    logic [7:0]                  intf;
    logic [7:0]                  clr_pulse;
    logic [31:0]                 rdata_next;
    logic                        accept;
    logic                        wr_fcnt;
    logic                        wr_inte;
    logic                        wr_intf;

    cfc_flt_if flt ();

    // Address phase taken on a selected non-idle transfer
    assign accept = hsel && htrans[1] && hready;

    // Data phase kind for the next cycle
    always_comb begin
        phase_next = cfc_pkg::CFC_IDLE;
        if (accept) begin
            phase_next = hwrite ? cfc_pkg::CFC_WRITE : cfc_pkg::CFC_READ;
        end
    end

    // Phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= cfc_pkg::CFC_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Address held for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= 12'h000;
        end else if (accept) begin
            addr_reg <= haddr[11:0];
        end
    end

    // Write strobes during a write data phase
    assign wr_fcnt = (phase_reg == cfc_pkg::CFC_WRITE) && (addr_reg == cfc_pkg::ADDR_FCNT);
    assign wr_inte = (phase_reg == cfc_pkg::CFC_WRITE) && (addr_reg == cfc_pkg::ADDR_INTE);
    assign wr_intf = (phase_reg == cfc_pkg::CFC_WRITE) && (addr_reg == cfc_pkg::ADDR_INTF);

    // Filter data bit count; an out-of-range value is kept but compares no bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fcnt_reg <= cfc_pkg::FCNT_RST;
        end else if (wr_fcnt) begin
            fcnt_reg <= hwdata[cfc_pkg::FCNT_W-1:0];
        end
    end

    // Interrupt enables, unused bits forced low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inte_reg <= cfc_pkg::IRQ_RST;
        end else if (wr_inte) begin
            inte_reg <= hwdata[7:0] & cfc_pkg::IRQ_MASK;
        end
    end

    // Writing a one clears the matching flag
    assign clr_pulse = wr_intf ? hwdata[7:0] : 8'h00;

    // Read data chosen from the address phase; unmapped reads return zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (haddr[11:0])
            cfc_pkg::ADDR_FCNT: rdata_next = {27'h0000000, fcnt_reg};
            cfc_pkg::ADDR_INTE: rdata_next = {24'h000000, inte_reg};
            cfc_pkg::ADDR_INTF: rdata_next = {24'h000000, intf};
            default:            rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (accept && !hwrite) begin
            hrdata <= rdata_next;
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Comparison request toward the comparator
    assign flt.req     = flt_req;
    assign flt.count   = fcnt_reg;
    assign flt.extended_identifier     = flt_eid;
    assign flt.payload = flt_payload;
    assign flt_valid      = flt.valid;
    assign flt_data_match = flt.data_match;

    // Acceptance comparator
    cfc_flt_cmp u_cmp (
        .hclk    (hclk),
        .hresetn (hresetn),
        .flt     (flt.cmp)
    );

    // Event flags and interrupt gating
    cfc_irq_ctl u_irq (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .event_pulse (event_pulse),
        .clr_pulse   (clr_pulse),
        .enable      (inte_reg),
        .flags       (intf),
        .irq         (irq)
    );

    // Checks, all on the bus clock
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Accepted read at a given register
    sequence s_rd_fcnt;
        accept && !hwrite && (haddr[11:0] == cfc_pkg::ADDR_FCNT);
    endsequence
    sequence s_rd_inte;
        accept && !hwrite && (haddr[11:0] == cfc_pkg::ADDR_INTE);
    endsequence
    // Accepted write at the enable register
    sequence s_wr_inte;
        accept && hwrite && (haddr[11:0] == cfc_pkg::ADDR_INTE);
    endsequence

    // Count write lands in the register
    chk_fcnt_write: assert property (
        wr_fcnt |=> fcnt_reg == $past(hwdata[4:0]))
        else $error("count write not stored");

    // Count zero always matches on data
    chk_zero_count: assert property (
        flt_req && (fcnt_reg == 5'h00) |=> flt_valid && flt_data_match)
        else $error("count zero compared data bits");

    // Count one compares identifier bit 0 with byte 1 bit 7
    chk_one_count: assert property (
        flt_req && (fcnt_reg == 5'h01)
        |=> flt_data_match == ($past(flt_eid[0]) == $past(flt_payload[23])))
        else $error("count one comparison wrong");

    // Count seventeen reaches identifier bit 17 and byte 3 bit 6
    chk_wide_count: assert property (
        flt_req && (fcnt_reg == cfc_pkg::FCNT_MAX) && (flt_eid[17] != flt_payload[6])
        |=> flt_valid && !flt_data_match)
        else $error("count seventeen missed last bit");

    // Middle counts: last compared pair decides a mismatch, next pair is ignored
    chk_mid_count: assert property (
        flt_req && (fcnt_reg >= 5'h02) && (fcnt_reg <= 5'h10)
        && (flt_eid[fcnt_reg - 5'h01] != flt_payload[5'h18 - fcnt_reg])
        |=> !flt_data_match)
        else $error("middle count comparison wrong");

    chk_mid_extent: assert property (
        flt_req && (fcnt_reg >= 5'h02) && (fcnt_reg <= 5'h10)
        && ((flt_eid & cfc_pkg::cfc_cmp_mask(fcnt_reg))
            == (cfc_pkg::cfc_stream(flt_payload) & cfc_pkg::cfc_cmp_mask(fcnt_reg)))
        |=> flt_data_match)
        else $error("middle count compared too many bits");

    // Invalid counts store but compare nothing
    chk_bad_count: assert property (
        flt_req && (fcnt_reg > cfc_pkg::FCNT_MAX) |=> flt_data_match)
        else $error("invalid count compared bits");

    // Invalid message flag passes only while enabled
    chk_ivr_gate: assert property (
        (intf == 8'h80) && !inte_reg[cfc_pkg::BIT_IVR] |=> !irq)
        else $error("invalid message not blocked");

    chk_wak_gate: assert property (
        intf[cfc_pkg::BIT_WAK] && inte_reg[cfc_pkg::BIT_WAK] |=> irq)
        else $error("wake event not passed");

    chk_err_gate: assert property (
        intf[cfc_pkg::BIT_ERR] && inte_reg[cfc_pkg::BIT_ERR] |=> irq)
        else $error("error event not passed");

    chk_fifo_gate: assert property (
        intf[cfc_pkg::BIT_FIFO] && inte_reg[cfc_pkg::BIT_FIFO] |=> irq)
        else $error("fifo event not passed");

    chk_rbov_gate: assert property (
        intf[cfc_pkg::BIT_RBOV] && inte_reg[cfc_pkg::BIT_RBOV] |=> irq)
        else $error("overflow event not passed");

    chk_rb_tb_gate: assert property (
        (intf[1:0] & inte_reg[1:0]) != 2'b00 |=> irq)
        else $error("buffer event not passed");

    // Enable write lands masked at the end of its data phase
    chk_inte_rw: assert property (
        s_wr_inte ##1 1'b1 |=> inte_reg == ($past(hwdata[7:0]) & cfc_pkg::IRQ_MASK))
        else $error("enable write not stored");

    // Enable read returns the register as it stood at the address phase
    chk_inte_rd: assert property (
        s_rd_inte |=> hrdata[7:0] == $past(inte_reg))
        else $error("enable read back wrong");

    // Unused bits of both registers read low
    chk_fcnt_zero: assert property (
        s_rd_fcnt |=> hrdata[31:5] == 27'h0000000)
        else $error("count upper bits not zero");

    chk_inte_zero: assert property (
        s_rd_inte |=> (hrdata[31:8] == 24'h000000) && !hrdata[4])
        else $error("enable unused bits not zero");

    // Interrupt follows enabled flags by one cycle, both ways
    chk_irq_level: assert property (
        ##1 irq == $past(|(intf & inte_reg)))
        else $error("interrupt level wrong");

    // Event arriving with its clear keeps the flag
    chk_set_wins: assert property (
        event_pulse[cfc_pkg::BIT_ERR] && clr_pulse[cfc_pkg::BIT_ERR]
        |=> intf[cfc_pkg::BIT_ERR])
        else $error("event lost to clear");
endmodule : cfc_top
`default_nettype wire

// File: common/cfc_pkg.sv
// Constants, types and helpers shared by the filter count and interrupt enable block
package cfc_pkg;
    // Register byte offsets
    localparam logic [11:0] ADDR_FCNT = 12'h000;
    localparam logic [11:0] ADDR_INTE = 12'h004;
    localparam logic [11:0] ADDR_INTF = 12'h008;
    // Field widths and reset values
    localparam int          FCNT_W    = 5;
    localparam int          EID_W     = 18;
    localparam int          PAY_W     = 24;
    localparam logic [4:0]  FCNT_RST  = 5'h00;
    localparam logic [4:0]  FCNT_MAX  = 5'h11;
    localparam logic [7:0]  IRQ_RST   = 8'h00;
    localparam logic [7:0]  IRQ_MASK  = 8'hEF;
    // Event and enable bit positions
    localparam int          BIT_IVR   = 7;
    localparam int          BIT_WAK   = 6;
    localparam int          BIT_ERR   = 5;
    localparam int          BIT_FIFO  = 3;
    localparam int          BIT_RBOV  = 2;
    localparam int          BIT_RB    = 1;
    localparam int          BIT_TB    = 0;

    // Bus data phase kinds
    typedef enum logic [1:0] {
        CFC_IDLE,
        CFC_WRITE,
        CFC_READ
    } cfc_phase_e;

    // Payload stream bit k is data byte 1 bit 7 onward, descending
    function automatic logic [EID_W-1:0] cfc_stream(input logic [PAY_W-1:0] pay);
        logic [EID_W-1:0] s;
        s = '0;
        for (int k = 0; k < EID_W; k++) begin
            s[k] = pay[PAY_W-1-k];
        end
        return s;
    endfunction : cfc_stream

    // Which identifier bits take part for a given count; invalid counts compare none
    function automatic logic [EID_W-1:0] cfc_cmp_mask(input logic [FCNT_W-1:0] cnt);
        logic [EID_W-1:0] m;
        m = '0;
        if (cnt == FCNT_MAX) begin
            m = '1;
        end else if (cnt < FCNT_MAX) begin
            for (int k = 0; k < EID_W; k++) begin
                m[k] = (k < int'(cnt));
            end
        end
        return m;
    endfunction : cfc_cmp_mask
endpackage : cfc_pkg

// File: common/cfc_flt_if.sv
// Interface carrying one acceptance comparison between the top and the comparator
`timescale 1ns/1ps
`default_nettype none
interface cfc_flt_if;
    logic                         req;
    logic [cfc_pkg::FCNT_W-1:0]   count;
    logic [cfc_pkg::EID_W-1:0]    extended_identifier;
    logic [cfc_pkg::PAY_W-1:0]    payload;
    logic                         valid;
    logic                         data_match;

    modport ctl (output req, output count, output extended_identifier, output payload,
                 input valid, input data_match);
    modport cmp (input req, input count, input extended_identifier, input payload,
                 output valid, output data_match);
endinterface : cfc_flt_if
`default_nettype wire

// File: rtl/cfc_flt_cmp.sv
// Payload against extended identifier comparator for acceptance filtering
`timescale 1ns/1ps
`default_nettype none
module cfc_flt_cmp (
    // Clock and reset
    input  wire logic  hclk,
    input  wire logic  hresetn,
    // Comparison request and result
    cfc_flt_if.cmp     flt
);
    logic [cfc_pkg::EID_W-1:0] diff;

    // Masked mismatch between identifier and leading payload bits
    assign diff = (flt.extended_identifier ^ cfc_pkg::cfc_stream(flt.payload))
                  & cfc_pkg::cfc_cmp_mask(flt.count);

    // Match result stands until the next request; valid is high only in the cycle after each request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flt.valid      <= 1'b0;
            flt.data_match <= 1'b0;
        end else begin
            flt.valid <= flt.req;
            if (flt.req) begin
                flt.data_match <= (diff == '0);
            end
        end
    end
endmodule : cfc_flt_cmp
`default_nettype wire

// File: rtl/cfc_irq_ctl.sv
// Sticky event flags, enable gating and the single interrupt output
`timescale 1ns/1ps
`default_nettype none
module cfc_irq_ctl (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Events, clears and enables
    input  wire logic [7:0]  event_pulse,
    input  wire logic [7:0]  clr_pulse,
    input  wire logic [7:0]  enable,
    // Flags and request
    output logic      [7:0]  flags,
    output logic             irq
);
    logic [7:0] flags_next;

    // A new event wins over a clear in the same cycle
    assign flags_next = ((flags & ~clr_pulse) | event_pulse) & cfc_pkg::IRQ_MASK;

    // Flag storage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= cfc_pkg::IRQ_RST;
        end else begin
            flags <= flags_next;
        end
    end

    // Request while any enabled flag is set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & enable);
        end
    end
endmodule : cfc_irq_ctl
`default_nettype wire

// File: test/cfc_node_model.sv
// Behavioural far-side node: raises controller events and asks for acceptance comparisons
`timescale 1ns/1ps
`default_nettype none
module cfc_node_model (
    // Clock
    input  wire logic         hclk,
    // Events toward the controller
    output logic      [7:0]   event_pulse,
    // Comparison request
    output logic              flt_req,
    output logic      [17:0]  flt_eid,
    output logic      [23:0]  flt_payload,
    // Comparison answer
    input  wire logic         flt_valid,
    input  wire logic         flt_data_match
);
    // Quiet lines from time zero
    initial begin
        event_pulse = 8'h00;
        flt_req     = 1'b0;
        flt_eid     = 18'h3FFFF;
        flt_payload = 24'h000000;
    end

    // One-cycle event pulse on the chosen sources
    task automatic fire(input logic [7:0] mask);
        @(posedge hclk);
        event_pulse <= mask;
        @(posedge hclk);
        event_pulse <= 8'h00;
    endtask : fire

    // One comparison; identifier and payload lines carry the inverse once released
    task automatic send_frame(input logic [17:0] extended_identifier, input logic [23:0] pay,
                              output logic vld, output logic mt);
        @(posedge hclk);
        flt_req     <= 1'b1;
        flt_eid     <= extended_identifier;
        flt_payload <= pay;
        @(posedge hclk);
        flt_req     <= 1'b0;
        flt_eid     <= ~extended_identifier;
        flt_payload <= ~pay;
        #1;
        vld = flt_valid;
        mt  = flt_data_match;
    endtask : send_frame
endmodule : cfc_node_model
`default_nettype wire

// File: test/cfc_top_bench.sv
// Self-checking bench for the filter count and interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module cfc_top_bench;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  event_pulse;
    logic        flt_req;
    logic [17:0] flt_eid;
    logic [23:0] flt_payload;
    logic        flt_valid;
    logic        flt_data_match;
    logic        irq;
    int          err_count;
    int          checks;
    logic [31:0] rd;
    logic        v;
    logic        m;
    logic [17:0] extended_identifier;
    logic [23:0] pay;
    int          c;
    int          bits [7] = '{7, 6, 5, 3, 2, 1, 0};

    cfc_top DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .event_pulse(event_pulse), .flt_req(flt_req), .flt_eid(flt_eid),
        .flt_payload(flt_payload), .flt_valid(flt_valid),
        .flt_data_match(flt_data_match), .irq(irq)
    );

    cfc_node_model NODE (
        .hclk(hclk), .event_pulse(event_pulse), .flt_req(flt_req), .flt_eid(flt_eid),
        .flt_payload(flt_payload), .flt_valid(flt_valid), .flt_data_match(flt_data_match)
    );

    // Clock of 20 ns period
    always #10 hclk = ~hclk;

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic print_verdict;
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // Address phase held until ready is seen at an edge
    task automatic addr_phase(input logic [31:0] a, input logic w);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask : addr_phase

    // Single word write
    task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
        addr_phase(a, 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask : ahb_write

    // Single word read, data taken at the closing edge of the data phase
    task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
        addr_phase(a, 1'b0);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask : ahb_read

    // Hang guard, far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        $display("ERROR %0t: run did not finish", $time);
        print_verdict();
    end

    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        err_count = 0;
        checks = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values and an unmapped place
        ahb_read(32'(cfc_pkg::ADDR_FCNT), rd);
        check(rd, 32'h00000000);
        ahb_read(32'(cfc_pkg::ADDR_INTE), rd);
        check(rd, 32'h00000000);
        ahb_read(32'(cfc_pkg::ADDR_INTF), rd);
        check(rd, 32'h00000000);
        ahb_read(32'h0000000C, rd);
        check(rd, 32'h00000000);
        check(32'(hresp), 32'h00000000);
        // Enable register keeps only its seven bits
        ahb_write(32'(cfc_pkg::ADDR_INTE), 32'hFFFFFFFF);
        ahb_read(32'(cfc_pkg::ADDR_INTE), rd);
        check(rd, 32'h000000EF);
        // Each enable passes its own event and blocks all others
        foreach (bits[i]) begin
            ahb_write(32'(cfc_pkg::ADDR_INTE), 32'h1 << bits[i]);
            NODE.fire(8'hEF & ~(8'h01 << bits[i]));
            repeat (2) @(posedge hclk);
            #1;
            check(32'(irq), 32'h00000000);
            NODE.fire(8'h01 << bits[i]);
            @(posedge hclk);
            #1;
            check(32'(irq), 32'h00000001);
            ahb_read(32'(cfc_pkg::ADDR_INTF), rd);
            check(rd, 32'h000000EF);
            ahb_write(32'(cfc_pkg::ADDR_INTF), 32'h000000FF);
            @(posedge hclk);
            #1;
            check(32'(irq), 32'h00000000);
        end
        // Event arriving in the data phase of its own clear keeps the flag
        fork
            ahb_write(32'(cfc_pkg::ADDR_INTF), 32'h00000020);
            begin
                @(posedge hclk);
                NODE.fire(8'h20);
            end
        join
        @(posedge hclk);
        ahb_read(32'(cfc_pkg::ADDR_INTF), rd);
        check(rd, 32'h00000020);
        ahb_write(32'(cfc_pkg::ADDR_INTF), 32'h000000FF);
        ahb_read(32'(cfc_pkg::ADDR_INTF), rd);
        check(rd, 32'h00000000);
        // Payload stream bit k faces identifier bit k
        extended_identifier = 18'h2D3A5;
        pay = 24'h000015;
        for (int k = 0; k < 18; k++) begin
            pay[23 - k] = extended_identifier[k];
        end
        // Every legal count: last compared bit differs, then first uncompared bit differs
        for (int n = 0; n <= 17; n++) begin
            ahb_write(32'(cfc_pkg::ADDR_FCNT), 32'hFFFFFFE0 | 32'(n));
            ahb_read(32'(cfc_pkg::ADDR_FCNT), rd);
            check(rd, 32'(n));
            c = (n == 17) ? 18 : n;
            for (int k = c - 1; k <= c; k++) begin
                if (k >= 0 && k < 18) begin
                    NODE.send_frame(extended_identifier, pay ^ (24'h800000 >> k), v, m);
                    check(32'(v), 32'h00000001);
                    check(32'(m), 32'(k >= c));
                end
            end
        end
        print_verdict();
    end
endmodule : cfc_top_bench
`default_nettype wire
